// ==== hdl/gpxi_consts.vh ====
// Constants of the GPIO expander interrupt logic and two-wire slave.
// Assumes inclusion by bare name from the design files of this block.
`ifndef GPXI_CONSTS_VH
`define GPXI_CONSTS_VH

// ----------------------------------------------------------------
// Register pointer offsets (one byte each)
// ----------------------------------------------------------------
`define GPXI_OFS_IN0 8'h00
`define GPXI_OFS_IN1 8'h01
`define GPXI_OFS_DIR0 8'h02
`define GPXI_OFS_DIR1 8'h03
`define GPXI_OFS_MASK0 8'h04
`define GPXI_OFS_MASK1 8'h05
`define GPXI_OFS_STAT0 8'h06
`define GPXI_OFS_STAT1 8'h07

// ----------------------------------------------------------------
// Reset values and field positions
// ----------------------------------------------------------------
`define GPXI_MASK_RST 16'hFFFF
`define GPXI_DIR_RST 16'hFFFF
`define GPXI_SNAP_RST 16'h0000
`define GPXI_UNMAPPED_RD 8'h00
`define GPXI_RW_BIT 0
`define GPXI_LAST_BIT 3'h7

`endif

// ==== hdl/gpxi_sync2.v ====
// Two-flop synchroniser for a bundle of independent level signals.
// Assumes each bit is a slow level from outside the clk_in domain.
`timescale 1ns/1ps
`default_nettype none

module gpxi_sync2 #(
  parameter W = 1,
  parameter [W-1:0] RST_VAL = {W{1'b1}}
) (
  // Clock and reset
  input wire clk_in,
  input wire sys_rst_in,
  // Levels
  input wire [W-1:0] async_in,
  output reg [W-1:0] sync_out
);

  reg [W-1:0] meta;

  // First stage feeds only the second stage
  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      meta <= RST_VAL;
      sync_out <= RST_VAL;
    end else begin
      meta <= async_in;
      sync_out <= meta;
    end
  end

endmodule

`default_nettype wire

// ==== hdl/gpxi_buf2.v ====
// Small FIFO with valid and ready on both sides.
// Assumes one clock; depth is 2 to the power AW, two entries by default.
`timescale 1ns/1ps
`default_nettype none

module gpxi_buf2 #(
  parameter W = 16,
  parameter AW = 1
) (
  // Clock and reset
  input wire clk_in,
  input wire sys_rst_in,
  // Filling side
  input wire in_valid_in,
  input wire [W-1:0] in_data_in,
  output wire in_ready_out,
  // Draining side
  output wire out_valid_out,
  output wire [W-1:0] out_data_out,
  input wire out_ready_in
);

  localparam DEPTH = 1 << AW;

  reg [W-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr;
  reg [AW-1:0] rd_ptr;
  reg [AW:0] count;
  wire push;
  wire pop;

  // Honest full and empty from the occupancy count
  assign in_ready_out = (count != DEPTH[AW:0]);
  assign out_valid_out = (count != {(AW+1){1'b0}});
  assign out_data_out = mem[rd_ptr];
  assign push = in_valid_in & in_ready_out;
  assign pop = out_valid_out & out_ready_in;

  // Storage and pointers
  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        mem[wr_ptr] <= in_data_in;
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      if (push & ~pop) begin
        count <= count + 1'b1;
      end else if (pop & ~push) begin
        count <= count - 1'b1;
      end
    end
  end

endmodule

`default_nettype wire

// ==== hdl/gpxi_slave.v ====
// Two-wire serial slave with a 16-pin change-detect interrupt.
// Assumes bus lines and pins are asynchronous, sampled several times per serial clock period.
`timescale 1ns/1ps
`default_nettype none
`include "gpxi_consts.vh"

// Behaviour
// - Unmasked input pin changing level drives the open-drain low interrupt.
// - Interrupt releases when pin returns, or its input port is read.
// - Only reading the port holding the changed bits clears its condition.
// - Turning an output into an input may raise a spurious interrupt.
// - Device sits in standby whenever the bus is idle.
// - One data bit per clock pulse; data stable while clock high.
// - Data falling with clock high is START; rising is STOP.
// - Both lines rest high when the bus is not busy.
// - Each byte is eight bits plus acknowledge; byte count unlimited.
// - Addressed as receiver, the device acknowledges every byte; the code answers no to a data byte while the write buffer is full.
// - Acknowledger holds data low through the acknowledge clock high.
// - After a not-acknowledged read byte, device keeps data released.
// - Registers are written with single byte write transfers.
// - Registers are read with single byte read transfers.
// - Mask bit 0 enables, 1 disables its pin; all reset to 1.
// - Status shows interrupting pins, zero for masked pins.
module gpxi_slave #(
  parameter [6:0] DEV_ADDR = 7'h20, // Arbitrary default address
  parameter NPINS = 16
) (
  // Clock and reset
  input wire clk_in,
  input wire sys_rst_in,
  // Serial bus lines
  input wire scl_in,
  input wire sda_in,
  output reg sda_out,
  output reg sda_oe_out,
  // Interrupt line, open drain
  output reg irq_n_out,
  output reg irq_oe_out,
  // Port pins and their state
  input wire [NPINS-1:0] gpio_in,
  output reg [NPINS-1:0] gpio_dir_out,
  output reg [NPINS-1:0] irq_status_out,
  output reg standby_out
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  localparam [3:0] ST_IDLE = 4'h0;
  localparam [3:0] ST_ADDR = 4'h1;
  localparam [3:0] ST_CMD = 4'h2;
  localparam [3:0] ST_WDATA = 4'h3;
  localparam [3:0] ST_ACK = 4'h4;
  localparam [3:0] ST_RDATA = 4'h5;
  localparam [3:0] ST_RACK = 4'h6;
  wire [1:0] bus_s;
  wire scl_s;
  wire sda_s;
  wire [NPINS-1:0] pins_s;
  reg scl_d;
  reg sda_d;
  wire scl_rise;
  wire scl_fall;
  wire start_seen;
  wire stop_seen;

  reg [3:0] state;
  reg [3:0] after;
  reg [2:0] bit_cnt;
  reg [7:0] shreg;
  reg [7:0] pointer;
  reg got_byte;
  reg master_ack;
  reg drive_low;
  reg bus_busy;

  reg [NPINS-1:0] mask;
  reg [NPINS-1:0] snap;
  wire [NPINS-1:0] pend;
  reg [7:0] rd_byte;
  reg snap_lo;
  reg snap_hi;

  wire wr_push;
  wire wr_ready;
  wire wr_valid;
  wire [15:0] wr_entry;
  wire wr_pop;

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  // Bus lines rest high, so reset them high to avoid a false START
  gpxi_sync2 #(
    .W(2),
    .RST_VAL(2'h3)
  ) u_bus_sync (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .async_in({scl_in, sda_in}),
    .sync_out(bus_s)
  );

  // Pins pass two flops so each change is seen exactly once
  gpxi_sync2 #(
    .W(NPINS),
    .RST_VAL({NPINS{1'b0}})
  ) u_pin_sync (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .async_in(gpio_in),
    .sync_out(pins_s)
  );

  assign scl_s = bus_s[1];
  assign sda_s = bus_s[0];

  // Previous samples for edge finding
  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_d <= scl_s;
      sda_d <= sda_s;
    end
  end

  // ----------------------------------------------------------------
  // Bus conditions
  // ----------------------------------------------------------------
  // Data edges with clock held high are framing, not data
  assign start_seen = scl_s & scl_d & sda_d & ~sda_s;
  assign stop_seen = scl_s & scl_d & ~sda_d & sda_s;
  assign scl_rise = scl_s & ~scl_d;
  assign scl_fall = ~scl_s & scl_d;

  // Busy from START to STOP; idle bus means standby
  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      bus_busy <= 1'b0;
      standby_out <= 1'b1;
    end else begin
      if (start_seen) begin
        bus_busy <= 1'b1;
      end else if (stop_seen) begin
        bus_busy <= 1'b0;
      end
      standby_out <= ~bus_busy & ~start_seen;
    end
  end

  // ----------------------------------------------------------------
  // Read data selection
  // ----------------------------------------------------------------
  // Unmapped pointers read as zero
  always @* begin
    case (pointer)
      `GPXI_OFS_IN0: rd_byte = pins_s[7:0];
      `GPXI_OFS_IN1: rd_byte = pins_s[15:8];
      `GPXI_OFS_DIR0: rd_byte = gpio_dir_out[7:0];
      `GPXI_OFS_DIR1: rd_byte = gpio_dir_out[15:8];
      `GPXI_OFS_MASK0: rd_byte = mask[7:0];
      `GPXI_OFS_MASK1: rd_byte = mask[15:8];
      `GPXI_OFS_STAT0: rd_byte = pend[7:0];
      `GPXI_OFS_STAT1: rd_byte = pend[15:8];
      default: rd_byte = `GPXI_UNMAPPED_RD;
    endcase
  end

  // ----------------------------------------------------------------
  // Byte engine
  // ----------------------------------------------------------------
  // Pushes a received data byte with its pointer into the buffer
  assign wr_push = (state == ST_WDATA) & scl_fall & got_byte;

  // START or STOP restarts the engine; a repeated START keeps the pointer
  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      state <= ST_IDLE;
      after <= ST_IDLE;
      bit_cnt <= 3'h0;
      shreg <= 8'h00;
      pointer <= 8'h00;
      got_byte <= 1'b0;
      master_ack <= 1'b0;
      drive_low <= 1'b0;
      snap_lo <= 1'b0;
      snap_hi <= 1'b0;
    end else begin
      snap_lo <= 1'b0;
      snap_hi <= 1'b0;
      if (start_seen) begin
        state <= ST_ADDR;
        bit_cnt <= 3'h0;
        got_byte <= 1'b0;
        drive_low <= 1'b0;
      end else if (stop_seen) begin
        state <= ST_IDLE;
        drive_low <= 1'b0;
      end else begin
        case (state)
          ST_ADDR, ST_CMD, ST_WDATA: begin
            if (scl_rise) begin
              shreg <= {shreg[6:0], sda_s};
              bit_cnt <= bit_cnt + 3'h1;
              got_byte <= (bit_cnt == `GPXI_LAST_BIT);
            end else if (scl_fall & got_byte) begin
              got_byte <= 1'b0;
              state <= ST_ACK;
              drive_low <= 1'b1;
              if (state == ST_ADDR) begin
                if (shreg[7:1] != DEV_ADDR) begin
                  state <= ST_IDLE;
                  drive_low <= 1'b0;
                end
                after <= shreg[`GPXI_RW_BIT] ? ST_RDATA : ST_CMD;
              end else if (state == ST_CMD) begin
                pointer <= shreg;
                after <= ST_WDATA;
              end else begin
                drive_low <= wr_ready; // Full buffer answers no
                after <= ST_WDATA;
              end
            end
          end
          ST_ACK: begin
            // Low held across the whole acknowledge clock high
            if (scl_fall) begin
              bit_cnt <= 3'h0;
              state <= after;
              if (after == ST_RDATA) begin
                drive_low <= ~rd_byte[7];
                shreg <= {rd_byte[6:0], 1'b1};
                snap_lo <= (pointer == `GPXI_OFS_IN0);
                snap_hi <= (pointer == `GPXI_OFS_IN1);
              end else begin
                drive_low <= 1'b0;
              end
            end
          end
          ST_RDATA: begin
            if (scl_fall) begin
              bit_cnt <= bit_cnt + 3'h1;
              if (bit_cnt == `GPXI_LAST_BIT) begin
                drive_low <= 1'b0;
                state <= ST_RACK;
              end else begin
                drive_low <= ~shreg[7];
                shreg <= {shreg[6:0], 1'b1};
              end
            end
          end
          ST_RACK: begin
            if (scl_rise) begin
              master_ack <= ~sda_s;
            end else if (scl_fall) begin
              if (master_ack) begin
                // Further reads resend the same register, loaded on this fall
                bit_cnt <= 3'h0;
                state <= ST_RDATA;
                drive_low <= ~rd_byte[7];
                shreg <= {rd_byte[6:0], 1'b1};
                snap_lo <= (pointer == `GPXI_OFS_IN0);
                snap_hi <= (pointer == `GPXI_OFS_IN1);
              end else begin
                state <= ST_IDLE;
              end
            end
          end
          default: begin
            drive_low <= 1'b0;
          end
        endcase
      end
    end
  end

  // Open-drain data line: only ever pulls low
  always @(posedge clk_in) begin
    sda_out <= 1'b0;
    if (sys_rst_in) begin
      sda_oe_out <= 1'b0;
    end else begin
      sda_oe_out <= drive_low;
    end
  end

  // ----------------------------------------------------------------
  // Write buffer
  // ----------------------------------------------------------------
  // Decouples the bus from the register file; a stalled drain loses no acked byte
  gpxi_buf2 #(
    .W(16),
    .AW(1)
  ) u_wr_buf (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .in_valid_in(wr_push),
    .in_data_in({pointer, shreg}),
    .in_ready_out(wr_ready),
    .out_valid_out(wr_valid),
    .out_data_out(wr_entry),
    .out_ready_in(~(snap_lo | snap_hi))
  );

  // Drain stalls while a snapshot update is in flight
  assign wr_pop = wr_valid & ~(snap_lo | snap_hi);

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  // Mask and direction; other pointers accept and drop the byte
  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      mask <= `GPXI_MASK_RST;
      gpio_dir_out <= `GPXI_DIR_RST;
    end else if (wr_pop) begin
      case (wr_entry[15:8])
        `GPXI_OFS_DIR0: gpio_dir_out[7:0] <= wr_entry[7:0];
        `GPXI_OFS_DIR1: gpio_dir_out[15:8] <= wr_entry[7:0];
        `GPXI_OFS_MASK0: mask[7:0] <= wr_entry[7:0];
        `GPXI_OFS_MASK1: mask[15:8] <= wr_entry[7:0];
        default: mask <= mask;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Change detection and interrupt
  // ----------------------------------------------------------------
  // Snapshot per port, taken when its byte is sent; the other port's is kept
  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      snap <= `GPXI_SNAP_RST;
    end else begin
      if (snap_lo) begin
        snap[7:0] <= pins_s[7:0];
      end
      if (snap_hi) begin
        snap[15:8] <= pins_s[15:8];
      end
    end
  end

  // Live pending: a returning pin clears it; a new input vs stale snapshot fires
  assign pend = gpio_dir_out & ~mask & (pins_s ^ snap);

  // Registered drive of the open-drain interrupt line
  always @(posedge clk_in) begin
    irq_n_out <= 1'b0;
    if (sys_rst_in) begin
      irq_oe_out <= 1'b0;
      irq_status_out <= {NPINS{1'b0}};
    end else begin
      irq_oe_out <= |pend;
      irq_status_out <= pend;
    end
  end

endmodule

`default_nettype wire

// ==== bench/gpxi_slave_chk.sv ====
// Checker for the two-wire slave with pin interrupt; sees top ports only.
// Assumes scl_in and sda_in are the resolved bus levels.
`timescale 1ns/1ps
`default_nettype none

module gpxi_slave_chk #(
  parameter NPINS = 16
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // Bus lines
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe_out,
  // Interrupt
  input wire logic irq_n_out,
  input wire logic irq_oe_out,
  // Pins and state
  input wire logic [NPINS-1:0] gpio_in,
  input wire logic [NPINS-1:0] gpio_dir_out,
  input wire logic [NPINS-1:0] irq_status_out,
  input wire logic standby_out
);
  // ------------------
  // Line edge finder
  // ------------------
  logic [2:0] scl_q;
  logic [2:0] sda_q;
  logic seen_start;
  logic seen_stop;

  // Same depth as the slave's own synchronisers, so edges line up
  always @(posedge clk_in) begin
    scl_q <= {scl_q[1:0], scl_in};
    sda_q <= {sda_q[1:0], sda_in};
  end

  // Data edges while the clock stays high
  assign seen_start = scl_q[2] & scl_q[1] & sda_q[2] & ~sda_q[1];
  assign seen_stop = scl_q[2] & scl_q[1] & ~sda_q[2] & sda_q[1];

  // ------------------
  // Properties
  // ------------------
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (sys_rst_in);

  rst_vals_a: assert property (disable iff (1'b0) sys_rst_in |=>
    (gpio_dir_out == '1 && irq_status_out == '0 && !sda_oe_out && !irq_oe_out && standby_out))
    else $error("reset values wrong");
  irq_set_a: assert property ((irq_status_out != '0) |-> ##[0:1] irq_oe_out)
    else $error("pending pin without interrupt");
  irq_release_a: assert property ((irq_status_out == '0) |-> ##[0:1] !irq_oe_out)
    else $error("interrupt without pending pin");
  stat_inputs_a: assert property (
    (irq_status_out & ~gpio_dir_out & ~$past(gpio_dir_out)) == '0)
    else $error("output pin shows pending");
  start_busy_a: assert property (seen_start |-> ##[1:3] !standby_out)
    else $error("standby kept after start");
  stop_idle_a: assert property (seen_stop |-> ##[1:3] standby_out)
    else $error("standby missing after stop");
  idle_release_a: assert property (standby_out |-> !sda_oe_out)
    else $error("data pulled while bus idle");
  data_stable_a: assert property ($changed(sda_oe_out) |-> !scl_in)
    else $error("data moved while clock high");
  open_drain_a: assert property (!irq_n_out && !sda_out)
    else $error("open drain level not low");

  cover property ($rose(irq_oe_out));
  cover property ($fell(irq_oe_out));
  cover property (seen_start ##[1:3] !standby_out);
endmodule

bind gpxi_slave gpxi_slave_chk #(.NPINS(NPINS)) u_chk (
  .clk_in(clk_in),
  .sys_rst_in(sys_rst_in),
  .scl_in(scl_in),
  .sda_in(sda_in),
  .sda_out(sda_out),
  .sda_oe_out(sda_oe_out),
  .irq_n_out(irq_n_out),
  .irq_oe_out(irq_oe_out),
  .gpio_in(gpio_in),
  .gpio_dir_out(gpio_dir_out),
  .irq_status_out(irq_status_out),
  .standby_out(standby_out)
);
`default_nettype wire

// ==== bench/gpxi_bus_master.sv ====
// Behavioural bus master for the two-wire slave.
// Assumes the bench resolves the data wire with a pull-up.
`timescale 1ns/1ps
`default_nettype none

module gpxi_bus_master (
  // Bus lines
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_oe_out
);
  // Clock stands high between frames; both lines idle high
  initial begin
    scl_out = 1'b1;
    sda_oe_out = 1'b0;
  end

  // Caller only starts from idle or after an acknowledge; the long low
  // phase lets the slave drop its acknowledge before the clock rises
  task automatic start();
    #7;
    sda_oe_out = 1'b0;
    #240;
    scl_out = 1'b1;
    #120;
    sda_oe_out = 1'b1;
    #100;
    scl_out = 1'b0;
  endtask

  // Same long low phase, so no slave release lands in the clock high
  task automatic stop();
    #7;
    sda_oe_out = 1'b1;
    #240;
    scl_out = 1'b1;
    #120;
    sda_oe_out = 1'b0;
    #100;
  endtask

  // One bit per pulse; long low phase leaves the slave time to answer
  task automatic bit_io(input logic b, output logic r);
    #120;
    sda_oe_out = ~b;
    #100;
    scl_out = 1'b1;
    #50;
    r = sda_in;
    #50;
    scl_out = 1'b0;
  endtask

  // Eight bits then a released acknowledge slot
  task automatic tx(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
    end
    bit_io(1'b1, r);
    ack = ~r;
  endtask

  // Last byte of a read is not acknowledged
  task automatic rx(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, d[i]);
    end
    bit_io(last, r);
  endtask
endmodule
`default_nettype wire

// ==== bench/testbench.sv ====
// Self-checking bench for the two-wire slave with pin interrupt.
// Assumes the bus master model and the bound checker are compiled first.
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, exp, got) begin samples_checked++; if ((got) !== (exp)) begin errors++; \
  $display("[FAIL] %s expected %h seen %h", nm, exp, got); end end

module testbench;
  localparam logic [6:0] ADDR = 7'h20;
  logic clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic [15:0] gpio = 16'ha55a;
  logic [15:0] gpio_dir_out;
  logic scl;
  logic m_oe;
  logic sda_oe_out;
  logic irq_oe_out;
  logic standby_out;
  logic [15:0] irq_stat;
  wire sda_w = ~(m_oe | sda_oe_out);
  int errors = 0;
  int samples_checked = 0;
  logic [7:0] rv [0:7] = '{8'h5a, 8'ha5, 8'hff, 8'hff, 8'hff, 8'hff, 8'h00, 8'h00};

  always #20 clk_in = ~clk_in;

  gpxi_slave #(.DEV_ADDR(ADDR), .NPINS(16)) u_dut (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .scl_in(scl), .sda_in(sda_w),
    .sda_out(), .sda_oe_out(sda_oe_out), .irq_n_out(), .irq_oe_out(irq_oe_out),
    .gpio_in(gpio), .gpio_dir_out(gpio_dir_out), .irq_status_out(irq_stat),
    .standby_out(standby_out));

  gpxi_bus_master u_mst (.sda_in(sda_w), .scl_out(scl), .sda_oe_out(m_oe));

  // ------------------
  // Access tasks
  // ------------------
  task automatic wr(input logic [7:0] p, input logic [7:0] d, input int n);
    logic a;
    u_mst.start();
    u_mst.tx({ADDR, 1'b0}, a);
    `CHK("address ack", 1'b1, a)
    u_mst.tx(p, a);
    `CHK("pointer ack", 1'b1, a)
    for (int i = 0; i < n; i++) begin
      u_mst.tx(d, a);
      `CHK("data ack", 1'b1, a)
    end
    u_mst.stop();
  endtask

  task automatic rd(input logic [7:0] p, input logic [7:0] exp);
    logic a;
    logic [7:0] d;
    u_mst.start();
    u_mst.tx({ADDR, 1'b0}, a);
    `CHK("busy", 1'b0, standby_out)
    u_mst.tx(p, a);
    `CHK("pointer ack", 1'b1, a)
    u_mst.start();
    u_mst.tx({ADDR, 1'b1}, a);
    `CHK("read ack", 1'b1, a)
    u_mst.rx(1'b1, d);
    `CHK("read data", exp, d)
    `CHK("released", 1'b0, sda_oe_out)
    u_mst.stop();
    repeat (4) @(posedge clk_in);
    `CHK("idle", 1'b1, standby_out)
  endtask

  // Bounded wait, then the interrupt level must match
  task automatic wirq(input logic v);
    int k;
    k = 0;
    while (irq_oe_out !== v && k < 20) begin
      @(posedge clk_in);
      k++;
    end
    `CHK("interrupt", v, irq_oe_out)
  endtask

  task automatic setpin(input logic [15:0] v);
    @(posedge clk_in);
    #2;
    gpio = v;
  endtask

  task automatic close_out();
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ------------------
  // Tests
  // ------------------
  // Watchdog sized well above the whole sequence
  initial begin
    #2_000_000;
    errors++;
    close_out();
  end

  initial begin
    logic a;
    repeat (6) @(posedge clk_in);
    #2;
    sys_rst_in = 1'b0;
    repeat (4) @(posedge clk_in);
    // Reset values; port reads also take the snapshot
    for (int i = 0; i < 8; i++) begin
      rd(i[7:0], rv[i]);
    end
    rd(8'h08, 8'h00);
    // Another slave address is left unanswered
    u_mst.start();
    u_mst.tx({7'h21, 1'b0}, a);
    u_mst.stop();
    `CHK("foreign ack", 1'b0, a)
    // Masked pins stay silent and show no status
    setpin(16'ha552);
    repeat (12) @(posedge clk_in);
    `CHK("masked", 1'b0, irq_oe_out)
    `CHK("masked status", 16'h0000, irq_stat)
    setpin(16'ha55a);
    // Mask programmed: low byte with one data byte, high byte with three in one transfer
    wr(8'h04, 8'h00, 1);
    wr(8'h05, 8'hfe, 3);
    rd(8'h04, 8'h00);
    rd(8'h05, 8'hfe);
    // Change then return
    setpin(16'ha552);
    wirq(1'b1);
    rd(8'h06, 8'h08);
    `CHK("status", 16'h0008, irq_stat)
    setpin(16'ha55a);
    wirq(1'b0);
    // Changes on both ports; each read clears only its own
    setpin(16'ha452);
    wirq(1'b1);
    rd(8'h00, 8'h52);
    `CHK("other port pending", 1'b1, irq_oe_out)
    rd(8'h07, 8'h01);
    rd(8'h01, 8'ha4);
    wirq(1'b0);
    // Output pins do not interrupt; turning back to input may
    wr(8'h02, 8'hfe, 1);
    `CHK("direction", 16'hfffe, gpio_dir_out)
    setpin(16'ha453);
    repeat (12) @(posedge clk_in);
    `CHK("output pin", 1'b0, irq_oe_out)
    wr(8'h02, 8'hff, 1);
    wirq(1'b1);
    rd(8'h00, 8'h53);
    wirq(1'b0);
    close_out();
  end
endmodule
`default_nettype wire
